// ---- rtl/spcr_port.sv ----
// Serial control port with configuration, identification and readback registers
// Notes on behaviour
// - Only the long instruction is used; host keeps the width bit at one.
// - Width bit zero means 8-bit instruction, one means 16-bit; one after reset.
// - Writing one to soft reset returns internal registers to defaults.
// - Soft reset stays set until the host writes zero to it.
// - Bit order zero: MSB first, address decrements over multi-byte transfers.
// - Bit order one: LSB first, address increments over multi-byte transfers.
// - Pin select zero: shared pin reads and writes, separate pin floats.
// - Pin select one: writes on shared pin, reads on separate output pin.
// - Identification register is read only and returns the variant code.
// - Readback select zero: reads return buffer registers.
// - Readback select one: reads return active registers.
// - Update bit copies buffer to active and clears itself when done.
`timescale 1ns/1ns
module spcr_port #(
  parameter logic [7:0] VARIANT_CODE = 8'h5A // Arbitrary value
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic soft_reset_o,
  output logic readback_active_o,
  output logic update_pulse_o
);
  import spcr_pkg::*;

  // Whole state of the port in one word, filled by the comb process and registered once
  typedef struct packed {
    spcr_phase_type phase;
    logic sclk_q;
    logic [15:0] shift;
    logic [4:0] bcnt;
    logic [12:0] addr;
    logic [7:0] tx;
    logic out_bit;
    logic driving;
    logic [7:0] port_cfg;
    logic rb_buf;
    logic rb_act;
    logic upd;
    logic upd_pulse;
  } spcr_state_type;

  spcr_state_type r;
  spcr_state_type next_r;
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;

  // Pins cross into the clock domain through two flip-flops
  // Seen two clocks late, so each link clock level must last four clocks
  spcr_sync u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i({sclk_i, cs_n_i, sdio_i}),
    .sync_o(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign din_s = pins_s[0];

  // Register readback, bank chosen by the active readback select
  function automatic logic [7:0] reg_read(input logic [12:0] a, input spcr_state_type s);
    logic [7:0] v;
    // Unmapped offsets read as zero
    v = 8'h00;
    if (a == OFS_PORT_CONFIG) begin
      v = s.port_cfg;
    end else if (a == OFS_VARIANT) begin
      v = VARIANT_CODE;
    end else if (a == OFS_READBACK_SEL) begin
      v[BIT_READBACK_ACTIVE] = s.rb_act ? s.rb_act : s.rb_buf;
    end else if (a == OFS_UPDATE_ALL) begin
      v[BIT_UPDATE_ALL] = s.upd;
    end
    return v;
  endfunction : reg_read

  // Next register address of a multi-byte transfer
  function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
    return lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
  endfunction : step_addr

  // Received byte in the order chosen
  function automatic logic [7:0] rx_byte(input logic [15:0] sh, input logic lsb);
    return lsb ? sh[15:8] : sh[7:0];
  endfunction : rx_byte

  // Transfer sequencing and register updates
  always_comb begin
    logic lsb;
    logic long_mode;
    logic rise;
    logic fall;
    logic [15:0] sh;
    logic [15:0] instr;
    logic [7:0] wb;
    lsb = r.port_cfg[BIT_LSB_FIRST];
    long_mode = r.port_cfg[BIT_LONG_INSTR];
    // Edges of the synchronised link clock, which idles high after reset
    rise = sclk_s && !r.sclk_q;
    fall = !sclk_s && r.sclk_q;
    sh = lsb ? {din_s, r.shift[15:1]} : {r.shift[14:0], din_s};
    instr = 16'h0000;
    wb = 8'h00;
    // Every field holds unless a branch below changes it
    next_r = r;
    next_r.sclk_q = sclk_s;
    next_r.upd_pulse = 1'b0;
    // Self-clearing update moves buffered values into the active bank
    if (r.upd) begin
      next_r.rb_act = r.rb_buf;
      next_r.upd = 1'b0;
      next_r.upd_pulse = 1'b1;
    end
    // A raised select drops any partial byte and frees the pins
    if (cs_n_s) begin
      next_r.phase = ST_INSTR;
      next_r.bcnt = 5'h00;
      next_r.driving = 1'b0;
    end else if (rise) begin
      next_r.shift = sh;
      next_r.bcnt = 5'(r.bcnt + 5'h01);
      case (r.phase)
        ST_INSTR: begin
          if (next_r.bcnt == (long_mode ? LONG_INSTR_BITS : SHORT_INSTR_BITS)) begin
            if (long_mode) begin
              instr = sh;
            end else begin
              // Short form: read flag in bit 7, five address bits below
              instr = {8'h00, rx_byte(sh, lsb)};
              instr[15] = instr[7];
              instr[12:0] = {8'h00, instr[4:0]};
            end
            next_r.addr = instr[12:0];
            next_r.bcnt = 5'h00;
            next_r.phase = instr[15] ? ST_READ : ST_WRITE;
            next_r.tx = reg_read(instr[12:0], r);
            next_r.driving = instr[15];
          end
        end
        ST_WRITE: begin
          if (next_r.bcnt == BYTE_BITS) begin
            wb = rx_byte(sh, lsb);
            // Identification and unmapped offsets ignore writes
            if (r.addr == OFS_PORT_CONFIG) begin
              next_r.port_cfg = wb;
            end else if (r.addr == OFS_READBACK_SEL) begin
              next_r.rb_buf = wb[BIT_READBACK_ACTIVE];
            end else if (r.addr == OFS_UPDATE_ALL) begin
              next_r.upd = wb[BIT_UPDATE_ALL];
            end
            next_r.addr = step_addr(r.addr, lsb);
            next_r.bcnt = 5'h00;
          end
        end
        ST_READ: begin
          if (next_r.bcnt == BYTE_BITS) begin
            next_r.addr = step_addr(r.addr, lsb);
            // Next byte is captured now, so later writes miss it
            next_r.tx = reg_read(next_r.addr, r);
            next_r.bcnt = 5'h00;
          end
        end
        default: begin
          next_r.bcnt = 5'h00;
        end
      endcase
    end else if (fall && r.phase == ST_READ) begin
      // Present the next bit after each falling edge
      next_r.out_bit = lsb ? r.tx[0] : r.tx[7];
      next_r.tx = lsb ? {1'b0, r.tx[7:1]} : {r.tx[6:0], 1'b0};
    end
    // Soft reset holds every register at its default while set
    // Forcing it each cycle keeps the reset in force until the host clears it
    if (next_r.port_cfg[BIT_SOFT_RESET]) begin
      next_r.port_cfg = RST_PORT_CONFIG;
      next_r.port_cfg[BIT_SOFT_RESET] = 1'b1;
      next_r.rb_buf = RST_READBACK_SEL;
      next_r.rb_act = RST_READBACK_SEL;
      next_r.upd = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r.phase <= ST_INSTR;
      r.sclk_q <= 1'b1;
      r.shift <= 16'h0000;
      r.bcnt <= 5'h00;
      r.addr <= 13'h0000;
      r.tx <= 8'h00;
      r.out_bit <= 1'b0;
      r.driving <= 1'b0;
      r.port_cfg <= RST_PORT_CONFIG;
      r.rb_buf <= RST_READBACK_SEL;
      r.rb_act <= RST_READBACK_SEL;
      r.upd <= 1'b0;
      r.upd_pulse <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Pin drivers: shared pin or separate output pin carries read data
  // The same bit feeds both pins; only the enables tell them apart
  assign sdio_o = r.out_bit;
  assign sdo_o = r.out_bit;
  assign sdio_oe_n_o = !(r.driving && !r.port_cfg[BIT_OUT_PIN_SEL]);
  assign sdo_oe_n_o = !(r.driving && r.port_cfg[BIT_OUT_PIN_SEL]);
  assign soft_reset_o = r.port_cfg[BIT_SOFT_RESET];
  assign readback_active_o = r.rb_act;
  assign update_pulse_o = r.upd_pulse;
endmodule : spcr_port

// ---- shared/spcr_pkg.sv ----
// Package with offsets, field positions, reset values and states of the serial configuration port
package spcr_pkg;
  // Register offsets
  localparam logic [12:0] OFS_PORT_CONFIG = 13'h0000;
  localparam logic [12:0] OFS_VARIANT = 13'h0003;
  localparam logic [12:0] OFS_READBACK_SEL = 13'h0004;
  localparam logic [12:0] OFS_UPDATE_ALL = 13'h0232;
  // Field positions in the port configuration byte
  localparam int BIT_OUT_PIN_SEL = 0;
  localparam int BIT_LSB_FIRST = 1;
  localparam int BIT_SOFT_RESET = 2;
  localparam int BIT_LONG_INSTR = 3;
  // Field positions elsewhere
  localparam int BIT_READBACK_ACTIVE = 0;
  localparam int BIT_UPDATE_ALL = 0;
  // Values after reset: long instruction and its mirror set
  localparam logic [7:0] RST_PORT_CONFIG = 8'h18;
  localparam logic RST_READBACK_SEL = 1'b0;
  // Frame lengths in link clock bits
  localparam logic [4:0] LONG_INSTR_BITS = 5'h10;
  localparam logic [4:0] SHORT_INSTR_BITS = 5'h08;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  // Transfer phases
  typedef enum logic [1:0] {ST_INSTR, ST_WRITE, ST_READ, ST_IGNORE} spcr_phase_type;
endpackage : spcr_pkg

// ---- rtl/spcr_sync.sv ----
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ns
module spcr_sync (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  logic [2:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= 3'h7;
      sync_o <= 3'h7;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : spcr_sync

// ---- verification/spcr_port_asserts.sv ----
// Checker for the serial configuration port outputs
`timescale 1ns/1ns
module spcr_port_asserts (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_n_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic soft_reset_o,
  input wire logic readback_active_o,
  input wire logic update_pulse_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Idle link and the two steps of the update strobe
  sequence cs_idle; cs_n_i [*6]; endsequence
  sequence upd_step; update_pulse_o ##1 !update_pulse_o; endsequence
  data_same_a: assert property (sdo_o == sdio_o) else $error("Data outputs differ");
  oe_excl_a: assert property (sdio_oe_n_o || sdo_oe_n_o) else $error("Both pins driven");
  idle_oe_a: assert property (cs_idle |-> sdio_oe_n_o && sdo_oe_n_o)
    else $error("Pin driven while idle");
  oe_rel_a: assert property ($rose(cs_n_i) |-> ##[1:8] sdio_oe_n_o && sdo_oe_n_o)
    else $error("Pin not released");
  oe_frame_a: assert property ($fell(sdio_oe_n_o) || $fell(sdo_oe_n_o) |-> !cs_n_i)
    else $error("Pin driven outside frame");
  pulse_one_a: assert property (update_pulse_o |-> upd_step) else $error("Long update");
  sr_hold_a: assert property (cs_idle |-> $stable(soft_reset_o))
    else $error("Soft reset changed alone");
  sr_bank_a: assert property (soft_reset_o [*2] |-> !readback_active_o && !update_pulse_o)
    else $error("Bank kept in soft reset");
  rb_cause_a: assert property ($changed(readback_active_o) |-> update_pulse_o ||
    $past(update_pulse_o) || soft_reset_o || $past(soft_reset_o)) else $error("Bank moved");
endmodule : spcr_port_asserts
bind spcr_port spcr_port_asserts u_chk (.clock_i, .nrst_i, .sclk_i, .cs_n_i, .sdio_i,
  .sdio_o, .sdio_oe_n_o, .sdo_o, .sdo_oe_n_o, .soft_reset_o, .readback_active_o,
  .update_pulse_o);

// ---- verification/spcr_host.sv ----
// Host serial controller model that clocks frames into the port
`timescale 1ns/1ns
module spcr_host (
  input wire logic clock_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic dat_o,
  input wire logic sdio_i,
  input wire logic sdio_oe_n_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  // Idle link at time zero, clock held high between frames
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    dat_o = 1'b0;
  end
  // Long instruction then one or two bytes, either bit order
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [15:0] d,
    input logic n, lsb, sep, output logic [15:0] q);
    logic [15:0] w;
    int idx;
    w = {rd, 2'b00, a};
    q = 16'h0000;
    @(posedge clock_i) cs_n_o <= 1'b0;
    for (int i = 0; i < 24 + 8 * n; i++) begin
      idx = lsb ? ((i < 24) ? 8 : 0) + i % 8 : 31 - i;
      sclk_o <= 1'b0;
      dat_o <= (i < 16) ? w[lsb ? i : 15 - i] : d[idx];
      repeat (4) @(posedge clock_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      // A released pin reads as the inverse of its last level
      if (rd && i > 15) q[idx] = sep ? sdo_i ^ sdo_oe_n_i : sdio_i ^ sdio_oe_n_i;
    end
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask : xfer
endmodule : spcr_host

// ---- verification/spcr_port_tb.sv ----
// Bench for the serial configuration port
`timescale 1ns/1ns
module spcr_port_tb;
  import spcr_pkg::*;
  localparam logic [7:0] VC = 8'hC4; // Arbitrary value
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sclk, cs_n, hdat, sdio_o, sdio_oe_n_o, sdo_o, sdo_oe_n_o;
  logic soft_reset_o, readback_active_o, update_pulse_o;
  logic [15:0] q;
  int err_count = 0;
  int num_checks = 0;
  int upd_seen = 0;
  wire sdio_w = sdio_oe_n_o ? hdat : sdio_o;
  spcr_port #(.VARIANT_CODE(VC)) DUT (.clock_i, .nrst_i, .sclk_i(sclk), .cs_n_i(cs_n),
    .sdio_i(sdio_w), .sdio_o, .sdio_oe_n_o, .sdo_o, .sdo_oe_n_o, .soft_reset_o,
    .readback_active_o, .update_pulse_o);
  spcr_host host (.clock_i, .sclk_o(sclk), .cs_n_o(cs_n), .dat_o(hdat), .sdio_i(sdio_o),
    .sdio_oe_n_i(sdio_oe_n_o), .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o));
  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
    host.xfer(1'b0, a, {d, 8'h00}, 1'b0, lsb, 1'b0, q);
  endtask : wr
  task rd(input logic [12:0] a, input logic n, lsb, sep, input logic [15:0] e);
    host.xfer(1'b1, a, 16'h0000, n, lsb, sep, q);
    chk(q, e);
  endtask : rd
  task t_defaults;
    rd(OFS_PORT_CONFIG, 1'b0, 1'b0, 1'b0, 16'h1800);
    wr(OFS_VARIANT, 8'hFF, 1'b0);
    rd(OFS_VARIANT, 1'b0, 1'b0, 1'b0, {VC, 8'h00});
  endtask : t_defaults
  task t_banks;
    wr(OFS_READBACK_SEL, 8'h01, 1'b0);
    rd(OFS_READBACK_SEL, 1'b0, 1'b0, 1'b0, 16'h0100);
    wr(OFS_UPDATE_ALL, 8'h01, 1'b0);
    chk(16'(readback_active_o), 16'h0001);
    chk(16'(upd_seen), 16'h0001);
    rd(OFS_UPDATE_ALL, 1'b0, 1'b0, 1'b0, 16'h0000);
    wr(OFS_READBACK_SEL, 8'h00, 1'b0);
    rd(OFS_READBACK_SEL, 1'b0, 1'b0, 1'b0, 16'h0100);
    wr(OFS_UPDATE_ALL, 8'h01, 1'b0);
    chk(16'(upd_seen), 16'h0002);
    rd(OFS_READBACK_SEL, 1'b0, 1'b0, 1'b0, 16'h0000);
  endtask : t_banks
  task t_order;
    rd(OFS_READBACK_SEL, 1'b1, 1'b0, 1'b0, {8'h00, VC});
    wr(OFS_PORT_CONFIG, 8'h5A, 1'b0);
    rd(OFS_VARIANT, 1'b1, 1'b1, 1'b0, {VC, 8'h00});
    wr(OFS_PORT_CONFIG, 8'h18, 1'b1);
  endtask : t_order
  task t_pins;
    wr(OFS_PORT_CONFIG, 8'h99, 1'b0);
    rd(OFS_VARIANT, 1'b0, 1'b0, 1'b1, {VC, 8'h00});
    rd(OFS_VARIANT, 1'b0, 1'b0, 1'b0, {~VC, 8'h00});
    wr(OFS_PORT_CONFIG, 8'h18, 1'b0);
    rd(OFS_VARIANT, 1'b0, 1'b0, 1'b1, {~VC, 8'h00});
  endtask : t_pins
  task t_soft;
    wr(OFS_READBACK_SEL, 8'h01, 1'b0);
    wr(OFS_UPDATE_ALL, 8'h01, 1'b0);
    chk(16'(upd_seen), 16'h0003);
    wr(OFS_PORT_CONFIG, 8'h3C, 1'b0);
    chk(16'({soft_reset_o, readback_active_o}), 16'h0002);
    rd(OFS_READBACK_SEL, 1'b0, 1'b0, 1'b0, 16'h0000);
    rd(OFS_PORT_CONFIG, 1'b0, 1'b0, 1'b0, 16'h1C00);
    chk(16'(soft_reset_o), 16'h0001);
    wr(OFS_PORT_CONFIG, 8'h18, 1'b0);
    chk(16'(soft_reset_o), 16'h0000);
    chk(16'(upd_seen), 16'h0003);
  endtask : t_soft
  task tally_and_finish;
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Count update strobes as the design raises them
  always @(posedge clock_i) begin
    if (update_pulse_o === 1'b1) begin
      upd_seen <= upd_seen + 1;
    end
  end
  // Clock at 100 MHz
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // Watchdog well past the length of all frames
  initial begin
    #400000;
    err_count++;
    tally_and_finish;
  end
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_defaults;
    t_banks;
    t_order;
    t_pins;
    t_soft;
    tally_and_finish;
  end
endmodule : spcr_port_tb
